/* hdl/pscp_pkg.sv */
package pscp_pkg;

    // ****************************************
    // clocking and timing figures
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned POR_DELAY_US = 10;
    localparam int unsigned REQ_MIN_PULSE_US = 2;
    localparam int unsigned STATUS_LOW_MIN_US = 268;
    localparam int unsigned DONE_TO_USER_MIN_US = 175;
    localparam int unsigned DONE_TO_USER_MAX_US = 437;
    localparam int unsigned USER_INIT_PERIODS = 8576;

    function automatic int unsigned us_up(input int unsigned us);
        return (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    function automatic int unsigned us_down(input int unsigned us);
        return (us * 1000) / CLK_PERIOD_NS;
    endfunction

    localparam int unsigned POR_CYCLES = us_up(POR_DELAY_US);
    localparam int unsigned REQ_MIN_CYCLES = us_up(REQ_MIN_PULSE_US);
    localparam int unsigned STATUS_LOW_CYCLES = us_up(STATUS_LOW_MIN_US);
    localparam int unsigned INIT_MIN_CYCLES = us_up(DONE_TO_USER_MIN_US);
    localparam int unsigned INIT_MAX_CYCLES = us_down(DONE_TO_USER_MAX_US);

    // ****************************************
    // bitstream layout
    // ****************************************
    localparam int unsigned WORD_BITS = 32;
    localparam logic [4:0] LAST_BIT_IDX = 5'h1f;
    localparam logic [7:0] CONFIG_WORDS = 8'h20;
    localparam logic [1:0] EDGES_TO_INIT = 2'h2;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned OPT_INIT_DONE_BIT = 0;
    localparam int unsigned OPT_USER_CLK_BIT = 1;
    localparam int unsigned OPT_DUAL_IO_BIT = 2;
    localparam logic [2:0] OPT_RESET = 3'h0;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [6:0] {
        S_POR = 7'h01,
        S_CLEAR = 7'h02,
        S_LOAD = 7'h04,
        S_DONE = 7'h08,
        S_INIT = 7'h10,
        S_USER = 7'h20,
        S_ERR = 7'h40
    } pscp_state_e;

    typedef struct packed {
        logic [WORD_BITS-1:0] data;
        logic last;
    } pscp_word_s;

    typedef struct packed {
        logic dual_io;
        logic user_clk;
        logic init_done_en;
    } pscp_opt_s;

    typedef struct packed {
        logic req_n;
        logic status;
        logic done;
        logic bclk;
        logic bdata;
        logic uclk;
    } pscp_pins_s;

endpackage

/* hdl/pscp_fifo.sv */
module pscp_fifo #(
    parameter int unsigned WIDTH = 33,
    parameter int unsigned DEPTH = 8
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic flush_i,
    // fill side
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // drain side
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    wire empty = (wr_ptr_r == rd_ptr_r);
    wire push = in_valid_i && !full;
    wire pop = out_ready_i && !empty;

    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || flush_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

endmodule

/* hdl/pscp_loader.sv */
// Overview of operation
// - user mode: all three lines high; host low request restarts configuration.
// - status held low for the whole power-on delay.
// - load-complete held low from power-up and during data reception.
// - data pin released to user I/O after configuration, per option.
// - full bitstream needed; load-complete rises only after error-free reception.
// - init-done driven low until initialization ends, when option loaded.
// - internal oscillator: user mode 175 to 437 us after load-complete.
// - user clock option: user mode after 8576 user clock periods.
// - timing figures hold with decompression and security disabled.
// - host may hold status low externally; device keeps waiting.
module pscp_loader #(
    parameter int unsigned STATUS_LOW_CYCLES = pscp_pkg::STATUS_LOW_CYCLES,
    parameter int unsigned INIT_MIN_CYCLES = pscp_pkg::INIT_MIN_CYCLES,
    parameter int unsigned USER_INIT_PERIODS = pscp_pkg::USER_INIT_PERIODS
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // host-facing pins
    input wire logic reconfig_request_n_i,
    input wire logic status_n_i,
    output logic status_n_o,
    output logic status_n_oe_o,
    input wire logic load_complete_i,
    output logic load_complete_o,
    output logic load_complete_oe_o,
    input wire logic config_bit_clock_i,
    input wire logic serial_config_in_i,
    output logic serial_config_in_o,
    output logic serial_config_in_oe_o,
    input wire logic user_init_clock_i,
    output logic init_done_o,
    output logic init_done_oe_o,
    // configuration word stream
    output pscp_pkg::pscp_word_s cfg_word_o,
    output logic cfg_valid_o,
    input wire logic cfg_ready_i,
    // core side of the dual-purpose pin
    output logic user_io_o,
    input wire logic user_io_i,
    input wire logic user_io_oe_i,
    // status to the core
    output logic user_mode_o,
    output logic config_error_o
);
    import pscp_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    pscp_pins_s pins_raw;
    pscp_pins_s sync1_r;
    pscp_pins_s sync2_r;
    pscp_pins_s sync3_r;

    assign pins_raw = '{req_n: reconfig_request_n_i, status: status_n_i,
                        done: load_complete_i, bclk: config_bit_clock_i,
                        bdata: serial_config_in_i, uclk: user_init_clock_i};

    always_ff @(posedge sys_clk_i) begin
        sync1_r <= pins_raw;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
    end

    wire bclk_rise = sync2_r.bclk && !sync3_r.bclk;
    wire bclk_fall = !sync2_r.bclk && sync3_r.bclk;
    wire uclk_rise = sync2_r.uclk && !sync3_r.uclk;

    // ****************************************
    // reconfiguration request filter
    // ****************************************
    logic [31:0] req_cnt_r;
    // glitches shorter than the minimum pulse never restart a load
    wire req_hit = (req_cnt_r >= REQ_MIN_CYCLES);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || sync2_r.req_n) begin
            req_cnt_r <= '0;
        end else if (!req_hit) begin
            req_cnt_r <= req_cnt_r + 32'h1;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    pscp_state_e state_r;
    pscp_state_e state_nxt;
    logic [31:0] tmr_r;
    logic [31:0] uclk_cnt_r;
    logic [1:0] fall_cnt_r;
    pscp_opt_s opt_r;
    logic [7:0] word_cnt_r;
    logic [4:0] bit_cnt_r;
    logic [WORD_BITS-1:0] shift_r;
    logic [WORD_BITS-1:0] sum_r;
    logic pend_r;
    pscp_word_s pend_word_r;
    logic fifo_in_ready;

    wire in_load = (state_r == S_LOAD);
    wire [WORD_BITS-1:0] word_now = {shift_r[WORD_BITS-2:0], sync2_r.bdata};
    wire word_done = in_load && bclk_rise && (bit_cnt_r == LAST_BIT_IDX);
    wire last_word = (word_cnt_r == CONFIG_WORDS - 8'h1);
    wire sum_ok = (word_now == sum_r);
    // a new word while the previous one still waits means data was lost
    wire overflow = word_done && pend_r && !fifo_in_ready;
    wire clear_done = (tmr_r >= STATUS_LOW_CYCLES);
    // the count runs on in S_INIT so it spans from load-complete rising
    wire osc_init_done = (tmr_r >= INIT_MIN_CYCLES - 1);
    wire usr_init_done = (uclk_cnt_r >= USER_INIT_PERIODS);
    wire init_finish = opt_r.user_clk ? usr_init_done : osc_init_done;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_POR: begin
                if (tmr_r >= POR_CYCLES - 1) begin
                    state_nxt = S_CLEAR;
                end
            end
            S_CLEAR: begin
                // external hold on status keeps us here indefinitely
                if (clear_done && sync2_r.req_n && sync2_r.status) begin
                    state_nxt = S_LOAD;
                end
            end
            S_LOAD: begin
                if (overflow) begin
                    state_nxt = S_ERR;
                end else if (word_done && last_word) begin
                    state_nxt = sum_ok ? S_DONE : S_ERR;
                end
            end
            S_DONE: begin
                if (fall_cnt_r == EDGES_TO_INIT) begin
                    state_nxt = S_INIT;
                end
            end
            S_INIT: begin
                if (init_finish) begin
                    state_nxt = S_USER;
                end
            end
            default: begin
                state_nxt = state_r;
            end
        endcase
        if (req_hit && state_r != S_POR) begin
            state_nxt = S_CLEAR;
        end
    end

    wire leaving = (state_nxt != state_r);
    wire keep_tmr = (state_r == S_DONE) && (state_nxt == S_INIT);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_r <= S_POR;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || (leaving && !keep_tmr)) begin
            tmr_r <= '0;
        end else if (tmr_r != 32'hffffffff) begin
            tmr_r <= tmr_r + 32'h1;
        end
    end

    // ****************************************
    // initialization edge and clock counters
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || state_r != S_DONE) begin
            fall_cnt_r <= '0;
        end else if (bclk_fall && sync2_r.done) begin
            fall_cnt_r <= fall_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || state_r != S_INIT) begin
            uclk_cnt_r <= '0;
        end else if (uclk_rise && !usr_init_done) begin
            uclk_cnt_r <= uclk_cnt_r + 32'h1;
        end
    end

    // ****************************************
    // serial deserializer and checksum
    // ****************************************
    // bits arrive msb first; the last word is the xor of all before it
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !in_load) begin
            bit_cnt_r <= '0;
            word_cnt_r <= '0;
            sum_r <= '0;
        end else if (bclk_rise) begin
            shift_r <= word_now;
            bit_cnt_r <= bit_cnt_r + 5'h1;
            if (word_done) begin
                word_cnt_r <= word_cnt_r + 8'h1;
                sum_r <= sum_r ^ word_now;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || state_r == S_CLEAR) begin
            opt_r <= OPT_RESET;
        end else if (word_done && word_cnt_r == 8'h0) begin
            opt_r.init_done_en <= word_now[OPT_INIT_DONE_BIT];
            opt_r.user_clk <= word_now[OPT_USER_CLK_BIT];
            opt_r.dual_io <= word_now[OPT_DUAL_IO_BIT];
        end
    end

    // one-word skid ahead of the fifo: the host cannot be stalled,
    // so a full fifo only shows up as a load error
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || state_r == S_CLEAR) begin
            pend_r <= 1'b0;
        end else if (word_done && (!pend_r || fifo_in_ready)) begin
            pend_r <= 1'b1;
            pend_word_r <= '{data: word_now, last: last_word};
        end else if (fifo_in_ready) begin
            pend_r <= 1'b0;
        end
    end

    pscp_fifo #(
        .WIDTH($bits(pscp_word_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .flush_i(state_r == S_CLEAR),
        .in_data_i(pend_word_r),
        .in_valid_i(pend_r),
        .in_ready_o(fifo_in_ready),
        .out_data_o(cfg_word_o),
        .out_valid_o(cfg_valid_o),
        .out_ready_i(cfg_ready_i)
    );

    // ****************************************
    // pin drivers
    // ****************************************
    wire status_low = (state_r == S_POR) || (state_r == S_ERR) ||
                      ((state_r == S_CLEAR) &&
                       !(clear_done && sync2_r.req_n));
    wire done_low = (state_r == S_POR) || (state_r == S_CLEAR) ||
                    (state_r == S_LOAD) || (state_r == S_ERR);

    assign status_n_o = 1'b0;
    assign status_n_oe_o = status_low;
    assign load_complete_o = 1'b0;
    assign load_complete_oe_o = done_low;
    assign init_done_o = 1'b0;
    assign init_done_oe_o = opt_r.init_done_en && (state_r != S_USER);

    logic pin_o_r;
    logic pin_oe_r;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pin_o_r <= 1'b0;
            pin_oe_r <= 1'b0;
            user_mode_o <= 1'b0;
            config_error_o <= 1'b0;
            user_io_o <= 1'b0;
        end else begin
            pin_o_r <= user_io_i;
            pin_oe_r <= (state_nxt == S_USER) && opt_r.dual_io &&
                        user_io_oe_i;
            user_mode_o <= (state_nxt == S_USER);
            config_error_o <= (state_nxt == S_ERR);
            user_io_o <= (state_r == S_USER) && sync2_r.bdata;
        end
    end

    assign serial_config_in_o = pin_o_r;
    assign serial_config_in_oe_o = pin_oe_r;

endmodule

/* dv/pscp_loader_monitor.sv */
module pscp_loader_monitor #(
    parameter int unsigned INIT_MIN_CYCLES = 100
) (
    // clock, reset and pins
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic reconfig_request_n_i,
    input wire logic status_n_oe_o,
    input wire logic load_complete_oe_o,
    input wire logic serial_config_in_oe_o,
    input wire logic init_done_oe_o,
    input wire logic user_io_oe_i,
    // word stream and status
    input wire pscp_pkg::pscp_word_s cfg_word_o,
    input wire logic cfg_valid_o,
    input wire logic cfg_ready_i,
    input wire logic user_mode_o,
    input wire logic config_error_o
);
    import pscp_pkg::*;
    logic [15:0] since_done_r;
    logic [15:0] since_done_nxt;
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);
    // ****************************************
    // cycles since load-complete release, saturating so it never wraps
    // ****************************************
    assign since_done_nxt = load_complete_oe_o ? 16'h0 :
        since_done_r + {15'h0, ~&since_done_r};
    always_ff @(posedge sys_clk_i) begin
        since_done_r <= since_done_nxt;
    end
    // ****************************************
    // properties
    // ****************************************
    property p_por; $fell(srst_i) |-> (status_n_oe_o && load_complete_oe_o)[*8];
    endproperty
    a_por: assert property (p_por) else $error("lines free after reset");
    property p_user; $rose(user_mode_o) |->
        !status_n_oe_o && !load_complete_oe_o && !init_done_oe_o; endproperty
    a_user: assert property (p_user) else $error("line held in user");
    property p_err; config_error_o |-> status_n_oe_o && load_complete_oe_o;
    endproperty
    a_err: assert property (p_err) else $error("error with lines free");
    property p_rel; $fell(load_complete_oe_o) |-> !config_error_o; endproperty
    a_rel: assert property (p_rel) else $error("done after error");
    property p_min; $rose(user_mode_o) |-> since_done_r >= INIT_MIN_CYCLES - 1;
    endproperty
    a_min: assert property (p_min) else $error("user mode too early");
    property p_dual; $rose(serial_config_in_oe_o) |->
        user_mode_o && $past(user_io_oe_i); endproperty
    a_dual: assert property (p_dual) else $error("pin driven wrongly");
    property p_stall; cfg_valid_o && !cfg_ready_i && reconfig_request_n_i
        |=> cfg_valid_o && $stable(cfg_word_o); endproperty
    a_stall: assert property (p_stall) else $error("head lost");
    property p_stay; user_mode_o && reconfig_request_n_i |=> user_mode_o;
    endproperty
    a_stay: assert property (p_stay) else $error("user mode lost");
endmodule

bind pscp_loader pscp_loader_monitor #(.INIT_MIN_CYCLES(INIT_MIN_CYCLES)) u_mon (
    .sys_clk_i, .srst_i, .reconfig_request_n_i, .status_n_oe_o,
    .load_complete_oe_o, .serial_config_in_oe_o, .init_done_oe_o,
    .user_io_oe_i, .cfg_word_o, .cfg_valid_o, .cfg_ready_i, .user_mode_o,
    .config_error_o);

/* dv/pscp_host.sv */
module pscp_host (
    // line levels seen by the host
    input wire logic status_line_i,
    input wire logic done_line_i,
    // pins the host drives
    output logic req_n_o,
    output logic hold_n_o,
    output logic bclk_o,
    output logic bdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // the bit clock parks low between frames, never floating
    initial begin
        req_n_o = 1'b1;
        hold_n_o = 1'b1;
        bclk_o = 1'b0;
        bdata_o = 1'b0;
    end
    task automatic request(input int ns);
        req_n_o = 1'b0;
        #(ns);
        req_n_o = 1'b1;
    endtask
    task automatic hold(input int ns);
        hold_n_o = 1'b0;
        #(ns);
        hold_n_o = 1'b1;
    endtask
    task automatic load(input logic [31:0] w [32], input int s, input int n,
                        input bit watch = 1'b1);
        if (s == 0) begin
            // a host that ignores status counts from its request release
            if (watch) begin
                wait (status_line_i === 1'b1);
            end
            #2003;
        end
        for (int i = s * 32; i < (s + n) * 32; i++) begin
            bdata_o = w[i / 32][31 - i % 32];
            #80 bclk_o = 1'b1;
            #80 bclk_o = 1'b0;
        end
        // released data shows the inverse of the last bit, not a stale one
        bdata_o = ~bdata_o;
    endtask
    task automatic finish();
        wait (done_line_i === 1'b1);
        #83;
        repeat (2) begin
            #80 bclk_o = 1'b1;
            #80 bclk_o = 1'b0;
        end
    endtask
endmodule

/* dv/tb_passive_serial_config_port.sv */
`define CHK(a, b) begin \
    samples_checked++; \
    if ((a) !== (b)) begin \
        error_cnt++; \
        $display("Error %0t got %h exp %h", $time, a, b); \
    end \
end

module tb_passive_serial_config_port;
    timeunit 1ns;
    timeprecision 1ps;
    import pscp_pkg::*;
    localparam int unsigned INIT_MIN = 100;
    logic sys_clk_i, srst_i, cfg_ready_i, user_io_i, user_io_oe_i;
    logic uclk, uclk_run, cfg_valid_o, user_io_o, user_mode_o;
    logic status_n_oe_o, load_complete_oe_o, init_done_oe_o, config_error_o;
    logic serial_config_in_o, serial_config_in_oe_o;
    logic status_n_o, load_complete_o, init_done_o;
    pscp_word_s cfg_word_o;
    wire logic req_n, hold_n, bclk, bdata;
    // open-drain status and load-complete lines with pull-ups; the data pin is driven by the loader or the host
    wire logic status_w = (status_n_oe_o ? status_n_o : 1'b1) && hold_n;
    wire logic done_w = load_complete_oe_o ? load_complete_o : 1'b1;
    wire logic pin_w = serial_config_in_oe_o ? serial_config_in_o : bdata;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc;
    time t0;
    logic [31:0] w [32];
    logic [32:0] got [$];

    pscp_loader #(.STATUS_LOW_CYCLES(50), .INIT_MIN_CYCLES(INIT_MIN),
        .USER_INIT_PERIODS(20)) DUT (
        .sys_clk_i, .srst_i, .reconfig_request_n_i(req_n),
        .status_n_i(status_w), .status_n_o, .status_n_oe_o,
        .load_complete_i(done_w), .load_complete_o, .load_complete_oe_o,
        .config_bit_clock_i(bclk), .serial_config_in_i(pin_w),
        .serial_config_in_o, .serial_config_in_oe_o,
        .user_init_clock_i(uclk), .init_done_o, .init_done_oe_o,
        .cfg_word_o, .cfg_valid_o, .cfg_ready_i, .user_io_o, .user_io_i,
        .user_io_oe_i, .user_mode_o, .config_error_o);
    pscp_host host (.status_line_i(status_w), .done_line_i(done_w),
        .req_n_o(req_n), .hold_n_o(hold_n), .bclk_o(bclk), .bdata_o(bdata));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always #40 uclk = uclk_run & ~uclk;
    always @(posedge sys_clk_i) begin
        if (cfg_valid_o === 1'b1 && cfg_ready_i === 1'b1) begin
            got.push_back(cfg_word_o);
        end
    end
    // the load-complete line rises here, which is where init time starts;
    // the host only notices it a few cycles later, once its last bit clock falls
    always @(negedge load_complete_oe_o) begin
        t0 = $time;
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic upto(ref logic s, input logic v, input int lim);
        int k;
        k = 0;
        while (s !== v && k < lim) begin
            @(negedge sys_clk_i);
            k++;
        end
        `CHK(s, v)
    endtask
    task automatic mk(input logic [2:0] opt);
        w[0] = {29'h0, opt};
        w[31] = w[0];
        for (int i = 1; i < 31; i++) begin
            w[i] = 32'(i) * 32'h9e3779b9;
            w[31] ^= w[i];
        end
        got.delete();
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_por();
        repeat (900) @(negedge sys_clk_i);
        `CHK({status_n_oe_o, load_complete_oe_o, init_done_oe_o}, 3'h6)
        $display("t_por done");
    endtask
    task automatic t_osc();
        mk(3'h5);
        cfg_ready_i = 1'b0;
        host.load(w, 0, 9);
        `CHK({cfg_valid_o, config_error_o}, 2'h2)
        @(negedge sys_clk_i);
        cfg_ready_i = 1'b1;
        host.load(w, 9, 22);
        `CHK(load_complete_oe_o, 1'b1)
        host.load(w, 31, 1);
        upto(load_complete_oe_o, 1'b0, 20);
        `CHK({init_done_oe_o, init_done_o}, 2'h2)
        host.finish();
        `CHK(got.size(), 32)
        for (int k = 0; k < got.size() && k < 32; k++) begin
            `CHK(got[k], {w[k], k == 31})
        end
        upto(user_mode_o, 1'b1, 1000);
        cyc = int'(($time - t0) / 10);
        `CHK(cyc >= INIT_MIN && cyc <= INIT_MIN + 5, 1'b1)
        `CHK({status_n_oe_o, load_complete_oe_o, init_done_oe_o}, 3'h0)
        host.finish();
        host.request(1000);
        repeat (20) @(negedge sys_clk_i);
        `CHK(user_mode_o, 1'b1)
        user_io_oe_i = 1'b1;
        for (int v = 0; v < 2; v++) begin
            user_io_i = v[0];
            repeat (4) @(negedge sys_clk_i);
            `CHK({serial_config_in_oe_o, serial_config_in_o}, {1'b1, v[0]})
        end
        user_io_oe_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        `CHK({serial_config_in_oe_o, user_io_o}, {1'b0, bdata})
        $display("t_osc done");
    endtask
    task automatic t_uclk();
        mk(3'h2);
        fork
            host.hold(6000);
        join_none
        host.request(3000);
        `CHK({status_n_oe_o, user_mode_o}, 2'h2)
        #1500;
        `CHK({status_n_oe_o, load_complete_oe_o}, 2'h1)
        host.load(w, 0, 32);
        upto(load_complete_oe_o, 1'b0, 20);
        host.finish();
        // user clock periods only count once the two edges started init
        #200;
        uclk_run = 1'b1;
        t0 = $time;
        upto(user_mode_o, 1'b1, 1000);
        cyc = int'(($time - t0) / 10);
        `CHK(cyc >= 155 && cyc <= 175, 1'b1)
        `CHK(init_done_oe_o, 1'b0)
        $display("t_uclk done");
    endtask
    task automatic t_bad();
        mk(3'h0);
        w[31] ^= 32'h1;
        host.request(2500);
        `CHK(user_mode_o, 1'b0)
        host.load(w, 0, 32, 1'b0);
        repeat (20) @(negedge sys_clk_i);
        `CHK({config_error_o, load_complete_oe_o, status_n_oe_o}, 3'h7)
        $display("t_bad done");
    endtask

    initial begin
        srst_i = 1'b1;
        cfg_ready_i = 1'b1;
        user_io_i = 1'b0;
        user_io_oe_i = 1'b0;
        uclk = 1'b0;
        uclk_run = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        srst_i = 1'b0;
        t_por();
        t_osc();
        t_uclk();
        t_bad();
        wrap_up();
    end
    // the three loads need about 0.53 ms; allow half again
    initial begin
        #800000;
        error_cnt++;
        wrap_up();
    end
endmodule
